// ==== pkg/gcs_pkg.sv ====
// shared constants, register map and types of the glitchless clock select block
`default_nettype none

package gcs_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ----------------------------------------------------------------
  localparam int           GCS_ADDR_WIDTH   = 12;
  localparam logic [11:0]  GCS_CTRL_OFFSET  = 12'h000;
  localparam logic [11:0]  GCS_STAT_OFFSET  = 12'h004;

  // control register fields
  localparam int           GCS_CTRL_WIDTH      = 5;
  localparam int           GCS_CTRL_SELECT_BIT = 0;
  localparam int           GCS_CTRL_FORCE_BIT  = 1;
  localparam int           GCS_CTRL_GATE_N_BIT = 2;
  localparam int           GCS_CTRL_LEVEL_BIT  = 3;
  localparam int           GCS_CTRL_PWR_N_BIT  = 4;
  localparam logic [4:0]   GCS_CTRL_RESET      = 5'h10;

  // status register fields
  localparam int           GCS_STAT_ACTIVE_BIT  = 0;
  localparam int           GCS_STAT_LEVEL_BIT   = 1;
  localparam int           GCS_STAT_RUN_BIT     = 2;
  localparam int           GCS_STAT_SWITCH_BIT  = 3;
  localparam int           GCS_STAT_FORCED_BIT  = 4;
  localparam int           GCS_STAT_PENDING_BIT = 5;

  // ----------------------------------------------------------------
  // switchover counts, in edges of an input clock, and the size of the output bank
  // ----------------------------------------------------------------
  localparam logic [1:0]   GCS_PARK_LIMIT  = 2'h3;
  localparam logic [1:0]   GCS_HOLD_RISES  = 2'h2;
  localparam logic [1:0]   GCS_FORCE_RISES = 2'h2;
  localparam int           GCS_OUT_COUNT   = 10;

  typedef enum logic [1:0] {
    GCS_RUN,
    GCS_PARK,
    GCS_HOLD,
    GCS_FORCED
  } gcs_state_type;

  // word-aligned address match, used for every register decode
  function automatic logic gcs_addr_hit(input logic [11:0] addr, input logic [11:0] offset);
    return addr[11:2] == offset[11:2];
  endfunction

endpackage

`default_nettype wire

// ==== logic/gcs_sync2.sv ====
// two-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none

module gcs_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // only the second stage may be looked at from outside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule

`default_nettype wire

// ==== logic/gcs_edge_detect.sv ====
// edge detector for one sampled input clock
`timescale 1ns/100ps
`default_nettype none

module gcs_edge_detect (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_level,
  output logic      level_q,
  output logic      rise,
  output logic      fall
);

  logic level_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= clk_level;
    end
  end

  assign level_q = level_reg;
  assign rise    = clk_level & ~level_reg;
  assign fall    = ~clk_level & level_reg;

endmodule

`default_nettype wire

// ==== logic/gcs_clock_select.sv ====
// glitchless two-input clock select with a buffered output bank and apb control
`timescale 1ns/100ps
`default_nettype none

module gcs_clock_select
  import gcs_pkg::*;
#(
  parameter int         OUT_COUNT   = GCS_OUT_COUNT,
  parameter logic [1:0] PARK_LIMIT  = GCS_PARK_LIMIT,
  parameter logic [1:0] HOLD_RISES  = GCS_HOLD_RISES,
  parameter logic [1:0] FORCE_RISES = GCS_FORCE_RISES
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [GCS_ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      clock_in_first,
  input  wire logic                      clock_in_second,
  output logic      [OUT_COUNT-1:0]      buffered_clock_out,
  output logic      [OUT_COUNT-1:0]      buffered_clock_out_n
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [GCS_CTRL_WIDTH-1:0] ctrl_reg;
  logic [GCS_CTRL_WIDTH-1:0] ctrl_next;
  logic [31:0]               prdata_reg;
  logic [31:0]               prdata_next;
  logic                      pready_reg;
  logic                      pready_next;
  logic                      pslverr_reg;
  logic                      pslverr_next;

  gcs_state_type             state_reg;
  gcs_state_type             state_next;
  logic [1:0]                cnt_reg;
  logic [1:0]                cnt_next;
  logic                      active_reg;
  logic                      active_next;
  logic                      core_level_reg;
  logic                      core_level_next;
  logic                      force_prev_reg;

  logic [OUT_COUNT-1:0]      out_true_reg;
  logic [OUT_COUNT-1:0]      out_comp_reg;

  logic                      first_rise;
  logic                      second_rise;
  logic                      select_sync;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  wire        apb_setup  = psel & ~penable;
  wire        apb_access = psel & penable & pready_reg;
  wire        hit_ctrl   = gcs_addr_hit(paddr, GCS_CTRL_OFFSET);
  wire        hit_stat   = gcs_addr_hit(paddr, GCS_STAT_OFFSET);
  wire        ctrl_write = apb_access & pwrite & hit_ctrl & pstrb[0];

  wire        ctrl_select = ctrl_reg[GCS_CTRL_SELECT_BIT];
  wire        force_reg   = ctrl_reg[GCS_CTRL_FORCE_BIT];
  wire        gate_n      = ctrl_reg[GCS_CTRL_GATE_N_BIT];
  wire        gated_level_choice = ctrl_reg[GCS_CTRL_LEVEL_BIT];
  wire        power_down_n       = ctrl_reg[GCS_CTRL_PWR_N_BIT];

  wire [31:0] ctrl_word = {{(32-GCS_CTRL_WIDTH){1'b0}}, ctrl_reg};
  wire [5:0]  stat_bits = {select_sync != active_reg,
                           state_reg == GCS_FORCED,
                           (state_reg == GCS_PARK) | (state_reg == GCS_HOLD),
                           state_reg == GCS_RUN,
                           core_level_reg,
                           active_reg};
  wire [31:0] stat_word = {26'h0000000, stat_bits};
  wire [31:0] read_word = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h00000000);

  // one wait-free access: answer is set up at the end of the setup cycle
  assign pready_next  = apb_setup;
  assign pslverr_next = apb_setup & ~(hit_ctrl | hit_stat);
  assign prdata_next  = (apb_setup & ~pwrite) ? read_word : 32'h00000000;
  assign ctrl_next    = ctrl_write ? pwdata[GCS_CTRL_WIDTH-1:0] : ctrl_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= GCS_CTRL_RESET;
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ----------------------------------------------------------------
  // input clock sampling and select synchronisation
  // ----------------------------------------------------------------
  gcs_edge_detect u_first_edge (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_level (clock_in_first),
    .level_q   (),
    .rise      (first_rise),
    .fall      ()
  );

  gcs_edge_detect u_second_edge (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_level (clock_in_second),
    .level_q   (),
    .rise      (second_rise),
    .fall      ()
  );

  // a select change only acts once it has cleared both flops
  gcs_sync2 #(
    .WIDTH (1)
  ) u_select_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (ctrl_select),
    .q       (select_sync)
  );

  // both switch paths look only at the active source, never the other one
  wire active_raw  = active_reg ? clock_in_second : clock_in_first;
  wire active_rise = active_reg ? second_rise : first_rise;
  wire sel_diff    = select_sync != active_reg;
  wire force_edge  = force_reg & ~force_prev_reg;

  // ----------------------------------------------------------------
  // switchover state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_next      = state_reg;
    cnt_next        = cnt_reg;
    active_next     = active_reg;
    core_level_next = core_level_reg;
    case (state_reg)
      GCS_RUN: begin
        core_level_next = active_raw;
        if (force_edge || (force_reg && sel_diff)) begin
          // park at once and take whatever select now says
          state_next      = GCS_FORCED;
          core_level_next = 1'b0;
          cnt_next        = 2'h0;
          active_next     = select_sync;
        end else if (sel_diff) begin
          state_next = GCS_PARK;
          cnt_next   = 2'h0;
        end
      end
      GCS_PARK: begin
        // follow the old clock down, then hold low
        core_level_next = core_level_reg & active_raw;
        if (active_rise) begin
          cnt_next = cnt_reg + 2'h1;
        end
        if (force_edge) begin
          state_next      = GCS_FORCED;
          core_level_next = 1'b0;
          cnt_next        = 2'h0;
          active_next     = select_sync;
        end else if (!core_level_next || cnt_reg == PARK_LIMIT) begin
          state_next      = GCS_HOLD;
          core_level_next = 1'b0;
          cnt_next        = 2'h0;
          active_next     = select_sync;
        end
      end
      GCS_HOLD: begin
        core_level_next = 1'b0;
        if (force_edge) begin
          state_next  = GCS_FORCED;
          cnt_next    = 2'h0;
          active_next = select_sync;
        end else if (active_rise) begin
          // low for a bounded count of new-clock cycles, restart on a rise
          if (cnt_reg == HOLD_RISES) begin
            state_next      = GCS_RUN;
            core_level_next = 1'b1;
          end else begin
            cnt_next = cnt_reg + 2'h1;
          end
        end
      end
      GCS_FORCED: begin
        core_level_next = 1'b0;
        if (sel_diff) begin
          // a late select change restarts the wait on the new source
          active_next = select_sync;
          cnt_next    = 2'h0;
        end else if (active_rise) begin
          if (cnt_reg == FORCE_RISES) begin
            // start only after some new-clock cycles
            state_next      = GCS_RUN;
            core_level_next = 1'b1;
          end else begin
            cnt_next = cnt_reg + 2'h1;
          end
        end
      end
      default: begin
        state_next      = GCS_RUN;
        core_level_next = 1'b0;
        cnt_next        = 2'h0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= GCS_RUN;
      cnt_reg        <= 2'h0;
      active_reg     <= 1'b0;
      core_level_reg <= 1'b0;
      force_prev_reg <= 1'b0;
    end else begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      active_reg     <= active_next;
      core_level_reg <= core_level_next;
      force_prev_reg <= force_reg;
    end
  end

  // ----------------------------------------------------------------
  // output bank: power-down, gate, then the switched clock
  // ----------------------------------------------------------------
  // gating here is asynchronous to the chosen clock, so runts are the caller's concern
  wire level_true = !power_down_n ? 1'b1 : (gate_n ? gated_level_choice : core_level_reg);
  wire level_comp = !power_down_n ? 1'b1 : (gate_n ? ~gated_level_choice : ~core_level_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_true_reg <= '0;
      out_comp_reg <= '1;
    end else begin
      out_true_reg <= {OUT_COUNT{level_true}};
      out_comp_reg <= {OUT_COUNT{level_comp}};
    end
  end

  assign buffered_clock_out   = out_true_reg;
  assign buffered_clock_out_n = out_comp_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  park_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == GCS_PARK && core_level_reg && !active_raw) |=> !core_level_reg)
    else $error("parked output did not fall with the old clock");

  park_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == GCS_PARK && !active_raw) |=> (state_reg != GCS_PARK))
    else $error("park did not end once the old clock was low");

  hold_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == GCS_HOLD) |-> (!core_level_reg && cnt_reg <= HOLD_RISES))
    else $error("hold interval not low or too long");

  resume_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(core_level_reg) |-> $past(active_rise))
    else $error("output rose without a rise of the active clock");

  force_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    force_edge |=> (!core_level_reg && state_reg == GCS_FORCED))
    else $error("force did not park the output at once");

  force_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == GCS_FORCED && state_next == GCS_RUN) |-> (active_reg == select_sync))
    else $error("forced restart on a clock other than the selected one");

  force_isolate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == GCS_RUN && force_reg && !sel_diff && !force_edge) |=>
      (core_level_reg == $past(active_reg ? clock_in_second : clock_in_first)))
    else $error("output disturbed by the deselected clock under force");

  force_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == GCS_FORCED && state_next == GCS_RUN) |-> (cnt_reg == FORCE_RISES && active_rise))
    else $error("forced restart without the wait on the new clock");

  pd_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!power_down_n) |=> ((&buffered_clock_out) && (&buffered_clock_out_n)))
    else $error("power-down outputs not both high");

  sync_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##2 (select_sync == $past(ctrl_select, 2)))
    else $error("select reached the switch without two flops");

endmodule

`default_nettype wire

// ==== verif/gcs_clock_src.sv ====
// model of the two clock sources feeding the select block
`timescale 1ns/100ps
`default_nettype none

module gcs_clock_src #(
  parameter int HALF_FIRST  = 330,
  parameter int HALF_SECOND = 470
) (
  input  wire logic first_dead,
  input  wire logic second_dead,
  output logic      clock_in_first,
  output logic      clock_in_second
);
  // ----------------------------------------------------------------
  // free-running sources
  // ----------------------------------------------------------------
  // odd start offsets keep source edges clear of pclk edges
  // a dead source parks at dc low, the way a failed driver would
  initial begin
    clock_in_first = 1'b0;
    #3;
    forever begin
      #(HALF_FIRST);
      clock_in_first = first_dead ? 1'b0 : ~clock_in_first;
    end
  end

  initial begin
    clock_in_second = 1'b0;
    #7;
    forever begin
      #(HALF_SECOND);
      clock_in_second = second_dead ? 1'b0 : ~clock_in_second;
    end
  end
endmodule

`default_nettype wire

// ==== verif/glitchless_clock_select_tb.sv ====
// self-checking bench for the glitchless clock select
`timescale 1ns/100ps
`default_nettype none

module glitchless_clock_select_tb;
  import gcs_pkg::*;

  localparam int HALF_FIRST  = 330;
  localparam int HALF_SECOND = 470;

  logic                     pclk;
  logic                     presetn;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [11:0]              paddr;
  logic [31:0]              pwdata;
  logic [3:0]               pstrb;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic                     clock_in_first;
  logic                     clock_in_second;
  logic                     first_dead;
  logic                     second_dead;
  logic [GCS_OUT_COUNT-1:0] buffered_clock_out;
  logic [GCS_OUT_COUNT-1:0] buffered_clock_out_n;
  int                       miscompares;
  int                       n_checks;

  gcs_clock_select u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_in_first(clock_in_first), .clock_in_second(clock_in_second),
    .buffered_clock_out(buffered_clock_out), .buffered_clock_out_n(buffered_clock_out_n)
  );

  gcs_clock_src #(.HALF_FIRST(HALF_FIRST), .HALF_SECOND(HALF_SECOND)) u_src (
    .first_dead(first_dead), .second_dead(second_dead),
    .clock_in_first(clock_in_first), .clock_in_second(clock_in_second)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // sample a little after the edge so registered outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no wait-state count is assumed; only the watchdog ends a stuck wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    apb(1'b1, GCS_CTRL_OFFSET, d, 4'hf, rd, e);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp, input logic xerr);
    logic [31:0] rd;
    logic        e;
    apb(1'b0, a, 32'h0, 4'hf, rd, e);
    check(what, rd, exp);
    check(what, {31'h0, e}, {31'h0, xerr});
  endtask

  task automatic wait_level(input logic v, input int limit, output int n);
    n = 0;
    while (buffered_clock_out[0] !== v && n < limit) begin
      tick(1);
      n++;
    end
  endtask

  // high width of the next full pulse, in pclk cycles, against a source half period
  task automatic pulse_chk(input string what, input int half);
    int n;
    int w;
    wait_level(1'b0, 200, n);
    wait_level(1'b1, 200, n);
    wait_level(1'b0, 200, w);
    check(what, {31'h0, (w * 40 >= half - 40 && w * 40 <= half + 40)}, 32'h1);
    check("bank", {22'h0, buffered_clock_out}, {22'h0, {GCS_OUT_COUNT{buffered_clock_out[0]}}});
    check("complement", {22'h0, buffered_clock_out_n}, {22'h0, ~buffered_clock_out});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] rd;
    logic        e;
    rd_chk("ctrl reset", GCS_CTRL_OFFSET, 32'h10, 1'b0);
    rd_chk("unmapped", 12'h008, 32'h0, 1'b1);
    apb(1'b1, 12'h008, 32'h1f, 4'hf, rd, e);
    apb(1'b1, GCS_CTRL_OFFSET, 32'h1f, 4'he, rd, e);
    apb(1'b1, GCS_STAT_OFFSET, 32'h3f, 4'hf, rd, e);
    rd_chk("ctrl kept", GCS_CTRL_OFFSET, 32'h10, 1'b0);
  endtask

  task automatic t_select();
    int n;
    pulse_chk("first running", HALF_FIRST);
    // start the change just after a rise, so no old pulse can restart before the park
    wait_level(1'b1, 200, n);
    wr(32'h11);
    wait_level(1'b0, 6 * HALF_FIRST / 40 + 6, n);
    check("park start", {31'h0, buffered_clock_out[0]}, 32'h0);
    wait_level(1'b1, 6 * HALF_SECOND / 40 + 6, n);
    check("park end", {31'h0, buffered_clock_out[0]}, 32'h1);
    wait_level(1'b0, 200, n);
    check("first new pulse", {31'h0, (n * 40 >= HALF_SECOND - 40)}, 32'h1);
    pulse_chk("second running", HALF_SECOND);
  endtask

  task automatic t_force_protect();
    int n;
    wait_level(1'b1, 200, n);
    wr(32'h10);
    pulse_chk("back on first", HALF_FIRST);
    wait_level(1'b1, 200, n);
    wr(32'h12);
    tick(2);
    check("forced low", {31'h0, buffered_clock_out[0]}, 32'h0);
    rd_chk("forced stat", GCS_STAT_OFFSET, 32'h10, 1'b0);
    pulse_chk("forced restart", HALF_FIRST);
    second_dead <= 1'b1;
    pulse_chk("deselected dead", HALF_FIRST);
    pulse_chk("deselected dead", HALF_FIRST);
    second_dead <= 1'b0;
    wr(32'h10);
  endtask

  task automatic t_dead_selected();
    first_dead <= 1'b1;
    tick(40);
    wr(32'h13);
    pulse_chk("takeover", HALF_SECOND);
    first_dead <= 1'b0;
    wr(32'h11);
    pulse_chk("after repair", HALF_SECOND);
  endtask

  task automatic t_gate_power();
    int n;
    // gate changes only while the output is low, so no runt pulse is cut
    wait_level(1'b0, 200, n);
    wr(32'h1d);
    tick(2);
    check("gated high", {12'h0, buffered_clock_out, buffered_clock_out_n}, {12'h0, 10'h3ff, 10'h000});
    wr(32'h15);
    tick(2);
    check("gated low", {12'h0, buffered_clock_out, buffered_clock_out_n}, {12'h0, 10'h000, 10'h3ff});
    wr(32'h05);
    tick(2);
    check("power down", {12'h0, buffered_clock_out, buffered_clock_out_n}, {12'h0, 10'h3ff, 10'h3ff});
    wr(32'h15);
    tick(4);
    wr(32'h11);
    pulse_chk("ungated", HALF_SECOND);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    #1_000_000;
    miscompares++;
    close_out();
  end

  initial begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0;
    pstrb       = 4'h0;
    first_dead  = 1'b0;
    second_dead = 1'b0;
    miscompares = 0;
    n_checks    = 0;
    tick(9);
    check("reset out", {12'h0, buffered_clock_out, buffered_clock_out_n}, {12'h0, 10'h000, 10'h3ff});
    check("reset rdata", prdata, 32'h0);
    check("reset bus", {30'h0, pready, pslverr}, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_select();
    t_force_protect();
    t_dead_selected();
    t_gate_power();
    close_out();
  end
endmodule

`default_nettype wire
